// File: shared/rtc_timer_consts.svh
// Offsets, field positions, reset values and pulse widths of the alarm/countdown unit.
// Assumes a 5-bit register address and 8-bit register data.
// Behaviour
// R1 - Weekday match: bit7 disable, 6..3 zero, 2..0 day
// R2 - All enabled match fields first equal sets flag
// R3 - Disabled match fields are left out
// R4 - Flag sticky; resets only on next new match
// R5 - Alarm interrupt enable makes output follow flag
// R6 - Countdown 8 bits at 10h, control at 11h
// R7 - Tick select bits 4..3, default slowest
// R8 - Run bit2, irq enable bit1, reset zero
// R9 - Bit0 selects level or per-period pulse
// R10 - Counts down from reload; zero stops timer
// R11 - Period is count times tick period
// R12 - Expiry from one sets flag and reloads
// R13 - Reload write takes effect immediately
// R14 - Software stops timer before changing reload; the bench rewrites the reload (05h, 00h) while the timer runs
// R15 - Slow sources start on a 64 Hz tick
// R16 - Countdown flag set each expiry, software clears
// R17 - Countdown read returns live count
// R18 - Slow ticks include correction pulses
// R19 - Software selects slowest tick when idle
// R20 - Pulse width depends on source and count
// R21 - Flag clear releases level interrupt same cycle
`ifndef RTC_TIMER_CONSTS_SVH
`define RTC_TIMER_CONSTS_SVH

`define RTC_OFS_SEC_MATCH   5'h0b
`define RTC_OFS_WDAY_MATCH  5'h0f
`define RTC_OFS_RELOAD      5'h10
`define RTC_OFS_CTRL        5'h11

`define RTC_MATCH_RST       8'h80
`define RTC_WDAY_MASK       8'h87
`define RTC_RELOAD_RST      8'h00
`define RTC_CTRL_RST        8'h18
`define RTC_CTRL_MASK       8'h1f

`define RTC_DIS_BIT         7
`define RTC_TSEL_HI         4
`define RTC_TSEL_LO         3
`define RTC_RUN_BIT         2
`define RTC_IRQ_EN_BIT      1
`define RTC_PULSE_SEL_BIT   0

// Interrupt pulse widths, counted in 8192 Hz ticks
`define RTC_PW_FAST_ONE     8'h01
`define RTC_PW_FAST         8'h02
`define RTC_PW_MID_ONE      8'h40
`define RTC_PW_SLOW         8'h80

`endif

// File: shared/rtc_timer_pkg.sv
// Types shared by the alarm/countdown unit.
// Assumes nothing beyond the constants header.
package rtc_timer_pkg;

    typedef enum logic [1:0] {
        TSEL_4096 = 2'b00,
        TSEL_64   = 2'b01,
        TSEL_1HZ  = 2'b10,
        TSEL_1_60 = 2'b11
    } tick_sel_t;

    typedef enum logic [1:0] {
        CD_IDLE = 2'b00,
        CD_ARM  = 2'b01,
        CD_RUN  = 2'b10
    } cd_state_t;

endpackage

// File: rtl/alarm_match.sv
// Compares enabled alarm match fields with the running time.
// Assumes time fields and the advance strobe are on mclk.
`timescale 1ns/100ps
`include "rtc_timer_consts.svh"
module alarm_match #(
    parameter int NFIELD = 5
) (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    // Match registers and current time, second first
    input  wire logic [NFIELD-1:0][7:0] match_regs,
    input  wire logic [NFIELD-1:0][6:0] cur_time,
    // Match event
    output logic                        hit
);
    import rtc_timer_pkg::*;

    typedef struct packed {
        logic prev;
        logic hit;
    } am_state_t;

    am_state_t          s_ff;
    am_state_t          nxt_s;
    logic [NFIELD-1:0]  field_ok;
    logic [NFIELD-1:0]  field_dis;
    logic               any_en;
    logic               match;

    genvar g;
    generate
        for (g = 0; g < NFIELD; g++)
        begin : g_cmp
            // A disabled field always agrees
            assign field_dis[g] = match_regs[g][`RTC_DIS_BIT];
            assign field_ok[g]  = field_dis[g] || (match_regs[g][6:0] == cur_time[g]); // R3
        end
    endgenerate

    // With every field disabled there is no alarm at all
    assign any_en = ~&field_dis;
    assign match  = any_en && (&field_ok);

    always_comb
    begin
        nxt_s      = s_ff;
        nxt_s.prev = match;
        nxt_s.hit  = match && !s_ff.prev; // R2 R4
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            s_ff <= '0;
        else if (ce)
            s_ff <= nxt_s;
    end

    assign hit = s_ff.hit;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_HIT_ON_NEW_MATCH: assert property (ce && match && !s_ff.prev |=> hit) // R2
        else $error("new match did not raise hit");
    AST_NO_REPEAT_HIT: assert property (ce && match && s_ff.prev |=> !hit) // R4
        else $error("hit repeated on a standing match");
endmodule // alarm_match

// File: rtl/int_pulse_gen.sv
// Timer interrupt pulse, width chosen from source and reload count.
// Assumes tick_8192 is a one-cycle mclk pulse.
`timescale 1ns/100ps
`include "rtc_timer_consts.svh"
module int_pulse_gen (
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst,
    input  wire logic                    ce,
    // Control
    input  wire logic                    start,
    input  wire rtc_timer_pkg::tick_sel_t tsel,
    input  wire logic                    t_is_one,
    input  wire logic                    tick_8192,
    // Pulse
    output logic                         active
);
    import rtc_timer_pkg::*;

    typedef struct packed {
        logic       on;
        logic [7:0] cnt;
    } pg_state_t;

    pg_state_t  s_ff;
    pg_state_t  nxt_s;
    logic [7:0] width;

    always_comb
    begin
        unique case (tsel)
            TSEL_4096: width = t_is_one ? `RTC_PW_FAST_ONE : `RTC_PW_FAST; // R20
            TSEL_64:   width = t_is_one ? `RTC_PW_MID_ONE : `RTC_PW_SLOW;  // R20
            TSEL_1HZ,
            TSEL_1_60: width = `RTC_PW_SLOW;                               // R20
        endcase
    end

    always_comb
    begin
        nxt_s = s_ff;
        if (start)
        begin
            nxt_s.on  = 1'b1;
            nxt_s.cnt = width;
        end
        else if (s_ff.on && tick_8192)
        begin
            nxt_s.cnt = s_ff.cnt - 8'h01;
            nxt_s.on  = (s_ff.cnt != 8'h01);
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            s_ff <= '0;
        else if (ce)
            s_ff <= nxt_s;
    end

    assign active = s_ff.on;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_PULSE_LOADS_WIDTH: assert property (ce && start |=> active && s_ff.cnt == $past(width)) // R20
        else $error("pulse did not start with its width");
endmodule // int_pulse_gen

// File: rtl/rtc_alarm_timer.sv
// Alarm match registers, countdown timer and interrupt output of the clock/calendar.
// Assumes the serial slave delivers one-cycle register strobes and that all
// prescaler ticks and time fields come from logic on mclk.
`timescale 1ns/100ps
`include "rtc_timer_consts.svh"
module rtc_alarm_timer (
    // Clock, reset, enable
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       ce,
    // Register port from the serial slave
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [4:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Running time, BCD
    input  wire logic [6:0] cur_sec,
    input  wire logic [6:0] cur_min,
    input  wire logic [6:0] cur_hour,
    input  wire logic [6:0] cur_day,
    input  wire logic [6:0] cur_wday,
    // Prescaler ticks, one cycle each
    input  wire logic       tick_8192,
    input  wire logic       tick_4096,
    input  wire logic       tick_64,
    input  wire logic       tick_1hz,
    input  wire logic       tick_1_60,
    // Control bits held elsewhere
    input  wire logic       alarm_irq_en,
    input  wire logic       alarm_flag_clr,
    input  wire logic       countdown_flag_clr,
    // Status and interrupt
    output logic            alarm_hit_flag,
    output logic            countdown_flag,
    output logic            int_n
);
    import rtc_timer_pkg::*;

    typedef struct packed {
        logic [4:0][7:0] match;
        logic [7:0]      reload;
        logic [7:0]      ctrl;
        logic [7:0]      cnt;
        cd_state_t       state;
        logic            alarm_flag;
        logic            cd_flag;
        logic [7:0]      rdata;
    } top_state_t;

    top_state_t s_ff;
    top_state_t nxt_s;

    logic       wr_match;
    logic       wr_reload;
    logic       wr_ctrl;
    logic [2:0] match_idx;
    logic       run;
    logic       cd_irq_en;
    logic       pulse_sel;
    tick_sel_t  tsel;
    logic       sel_tick;
    logic       slow_src;
    logic       fire;
    logic       alarm_hit;
    logic       pulse_on;
    logic       alarm_eff;
    logic       cd_eff;
    logic       cd_irq;
    logic [7:0] live_read;

    // Register decode
    assign match_idx = 3'(reg_addr - `RTC_OFS_SEC_MATCH);
    assign wr_match  = reg_wr && (reg_addr >= `RTC_OFS_SEC_MATCH) && (reg_addr <= `RTC_OFS_WDAY_MATCH);
    assign wr_reload = reg_wr && (reg_addr == `RTC_OFS_RELOAD); // R6
    assign wr_ctrl   = reg_wr && (reg_addr == `RTC_OFS_CTRL);   // R6

    // Control fields
    assign run       = s_ff.ctrl[`RTC_RUN_BIT];                        // R8
    assign cd_irq_en = s_ff.ctrl[`RTC_IRQ_EN_BIT];                     // R8
    assign pulse_sel = s_ff.ctrl[`RTC_PULSE_SEL_BIT];                  // R9
    assign tsel      = tick_sel_t'(s_ff.ctrl[`RTC_TSEL_HI:`RTC_TSEL_LO]); // R7
    assign slow_src  = (tsel == TSEL_1HZ) || (tsel == TSEL_1_60);

    // Slow ticks arrive already stretched or shortened by offset correction
    always_comb
    begin
        unique case (tsel)
            TSEL_4096: sel_tick = tick_4096; // R7
            TSEL_64:   sel_tick = tick_64;   // R7
            TSEL_1HZ:  sel_tick = tick_1hz;  // R18
            TSEL_1_60: sel_tick = tick_1_60; // R18
        endcase
    end

    // Expiry: a decrement from one, or from a count left zero by a racing write
    assign fire = (s_ff.state == CD_RUN) && run && (s_ff.reload != 8'h00) && sel_tick
                  && (s_ff.cnt <= 8'h01) && !wr_reload; // R12

    always_comb
    begin
        live_read = 8'h00;
        if ((reg_addr >= `RTC_OFS_SEC_MATCH) && (reg_addr <= `RTC_OFS_WDAY_MATCH))
            live_read = s_ff.match[match_idx];
        else if (reg_addr == `RTC_OFS_RELOAD)
            live_read = s_ff.cnt;                   // R17
        else if (reg_addr == `RTC_OFS_CTRL)
            live_read = s_ff.ctrl & `RTC_CTRL_MASK; // R8
    end

    always_comb
    begin
        nxt_s = s_ff;

        if (reg_rd)
            nxt_s.rdata = live_read;

        if (wr_match)
        begin
            if (reg_addr == `RTC_OFS_WDAY_MATCH)
                nxt_s.match[match_idx] = reg_wdata & `RTC_WDAY_MASK; // R1
            else
                nxt_s.match[match_idx] = reg_wdata;
        end

        if (wr_ctrl)
            nxt_s.ctrl = reg_wdata & `RTC_CTRL_MASK; // R8

        // Countdown sequencing
        unique case (s_ff.state)
            CD_IDLE:
            begin
                if (run && s_ff.reload != 8'h00)
                begin
                    nxt_s.cnt   = s_ff.reload;
                    // Counting starts on a tick boundary, so with a fast source the first period is never short:
                    // fast sources align to their own tick, slow ones to the 64 Hz grid
                    nxt_s.state = CD_ARM; // R15
                end
            end
            CD_ARM:
            begin
                if (!run || s_ff.reload == 8'h00)
                    nxt_s.state = CD_IDLE; // R10
                else if (slow_src ? tick_64 : sel_tick)
                    nxt_s.state = CD_RUN;  // R15
            end
            CD_RUN:
            begin
                if (!run || s_ff.reload == 8'h00)
                    nxt_s.state = CD_IDLE; // R10
                else if (fire)
                    nxt_s.cnt = s_ff.reload; // R12
                else if (sel_tick)
                    nxt_s.cnt = s_ff.cnt - 8'h01; // R11
            end
            default:
                nxt_s.state = CD_IDLE;
        endcase

        // A reload write lands in the live count at once, racing the tick
        if (wr_reload)
        begin
            nxt_s.reload = reg_wdata; // R13
            nxt_s.cnt    = reg_wdata; // R13
        end

        // Set wins over a clear arriving in the same cycle
        nxt_s.alarm_flag = alarm_hit || (s_ff.alarm_flag && !alarm_flag_clr); // R4
        nxt_s.cd_flag    = fire || (s_ff.cd_flag && !countdown_flag_clr);     // R16
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s_ff        <= '0;
            s_ff.match  <= {5{`RTC_MATCH_RST}};
            s_ff.reload <= `RTC_RELOAD_RST;
            s_ff.ctrl   <= `RTC_CTRL_RST;
            s_ff.state  <= CD_IDLE;
        end
        else if (ce)
            s_ff <= nxt_s;
    end

    alarm_match #(
        .NFIELD     (5)
    ) u_alarm (
        .mclk       (mclk),
        .rst        (rst),
        .ce         (ce),
        .match_regs (s_ff.match),
        .cur_time   ({cur_wday, cur_day, cur_hour, cur_min, cur_sec}),
        .hit        (alarm_hit)
    );

    int_pulse_gen u_pulse (
        .mclk      (mclk),
        .rst       (rst),
        .ce        (ce),
        .start     (fire && ce),
        .tsel      (tsel),
        .t_is_one  (s_ff.reload == 8'h01),
        .tick_8192 (tick_8192),
        .active    (pulse_on)
    );

    // A clear drops the level in its own cycle rather than one later
    assign alarm_eff = s_ff.alarm_flag && !alarm_flag_clr;                 // R21
    assign cd_eff    = s_ff.cd_flag && !countdown_flag_clr;                // R21
    assign cd_irq    = cd_irq_en && (pulse_sel ? pulse_on : cd_eff);       // R9 R20
    assign int_n     = !((alarm_irq_en && alarm_eff) || cd_irq);           // R5

    assign alarm_hit_flag = s_ff.alarm_flag;
    assign countdown_flag = s_ff.cd_flag;
    assign reg_rdata      = s_ff.rdata;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence seq_slow_start;
        ce && s_ff.state == CD_IDLE && run && s_ff.reload != 8'h00 && slow_src && !wr_ctrl && !wr_reload;
    endsequence

    sequence seq_armed;
        s_ff.state == CD_ARM;
    endsequence

    sequence seq_fast_align;
        ce && s_ff.state == CD_ARM && run && s_ff.reload != 8'h00 && !slow_src && sel_tick && !reg_wr;
    endsequence

    AST_WDAY_UNUSED_ZERO: assert property (ce && reg_rd && reg_addr == `RTC_OFS_WDAY_MATCH |=> reg_rdata[6:3] == 4'h0) // R1
        else $error("weekday match unused bits not zero");
    AST_LIVE_READ: assert property (ce && reg_rd && reg_addr == `RTC_OFS_RELOAD |=> reg_rdata == $past(s_ff.cnt)) // R17
        else $error("countdown read did not return live count");
    AST_EXPIRY_RELOAD: assert property (ce && fire |=> countdown_flag && s_ff.cnt == $past(s_ff.reload)) // R12
        else $error("expiry did not set flag and reload");
    AST_FLAG_STICKY: assert property (countdown_flag && !countdown_flag_clr |=> countdown_flag) // R16
        else $error("countdown flag dropped without clear");
    AST_ZERO_STOPS: assert property (ce && s_ff.reload == 8'h00 && !reg_wr |=> s_ff.state == CD_IDLE) // R10
        else $error("timer kept running with zero reload");
    AST_DECREMENT: assert property (ce && s_ff.state == CD_RUN && run && sel_tick && s_ff.cnt > 8'h01
                                    && s_ff.reload != 8'h00 && !reg_wr |=> s_ff.cnt == $past(s_ff.cnt) - 8'h01) // R11
        else $error("count did not step down on tick");
    AST_WRITE_IMMEDIATE: assert property (ce && wr_reload |=> s_ff.cnt == $past(reg_wdata)) // R13
        else $error("reload write not taken at once");
    AST_SLOW_ARM: assert property (seq_slow_start |=> seq_armed) // R15
        else $error("slow source start skipped 64 Hz alignment");
    AST_FAST_ALIGN: assert property (seq_fast_align |=> s_ff.state == CD_RUN && s_ff.cnt == $past(s_ff.cnt)) // R15
        else $error("fast source counted its aligning tick");
    AST_ALARM_LEVEL: assert property (alarm_irq_en && alarm_hit_flag && !alarm_flag_clr |-> !int_n) // R5
        else $error("interrupt not following alarm flag");
    AST_CLR_RELEASE: assert property ((alarm_flag_clr || !alarm_irq_en) && (countdown_flag_clr || !cd_irq_en)
                                      && !pulse_sel |-> int_n) // R21
        else $error("level interrupt held after clear");
endmodule // rtc_alarm_timer

// File: test/rtc_alarm_and_countdown_timer_bench.sv
// Self-checking bench for the alarm/countdown unit: register tasks, tick pulses and flag clears.
// Assumes the unit's register strobes, ticks and time fields are all sampled on rising mclk.
`timescale 1ns/100ps
`include "rtc_timer_consts.svh"
module rtc_alarm_and_countdown_timer_bench;
    import rtc_timer_pkg::*;

    logic       mclk;
    logic       rst;
    logic       ce;
    logic       reg_wr;
    logic       reg_rd;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [6:0] cur_sec;
    logic [6:0] cur_min;
    logic [6:0] cur_hour;
    logic [6:0] cur_day;
    logic [6:0] cur_wday;
    logic [4:0] tk;
    logic       alarm_irq_en;
    logic       alarm_flag_clr;
    logic       countdown_flag_clr;
    logic       alarm_hit_flag;
    logic       countdown_flag;
    logic       int_n;
    int         n_errors;
    int         cmp_count;
    int         i;

    rtc_alarm_timer u_rtc_alarm_timer (
        .mclk               (mclk),
        .rst                (rst),
        .ce                 (ce),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_rdata          (reg_rdata),
        .cur_sec            (cur_sec),
        .cur_min            (cur_min),
        .cur_hour           (cur_hour),
        .cur_day            (cur_day),
        .cur_wday           (cur_wday),
        .tick_8192          (tk[0]),
        .tick_4096          (tk[1]),
        .tick_64            (tk[2]),
        .tick_1hz           (tk[3]),
        .tick_1_60          (tk[4]),
        .alarm_irq_en       (alarm_irq_en),
        .alarm_flag_clr     (alarm_flag_clr),
        .countdown_flag_clr (countdown_flag_clr),
        .alarm_hit_flag     (alarm_hit_flag),
        .countdown_flag     (countdown_flag),
        .int_n              (int_n)
    );

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic tally_and_finish;
        begin
            if (n_errors == 0 && cmp_count > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        begin
            cmp_count++;
            if (got !== exp)
            begin
                n_errors++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
        begin
            @(negedge mclk);
            reg_addr  = a;
            reg_wdata = d;
            reg_wr    = 1'b1;
            @(negedge mclk);
            reg_wr    = 1'b0;
        end
    endtask

    // Read data is registered on the strobe edge and then held
    task automatic reg_read(input logic [4:0] a, input logic [7:0] exp);
        begin
            @(negedge mclk);
            reg_addr = a;
            reg_rd   = 1'b1;
            @(negedge mclk);
            reg_rd   = 1'b0;
            chk(reg_rdata, exp);
        end
    endtask

    // One-cycle prescaler pulse, then a spare cycle so registered flags settle
    task automatic tick(input int idx);
        begin
            @(negedge mclk);
            tk[idx] = 1'b1;
            @(negedge mclk);
            tk = 5'h00;
            @(negedge mclk);
        end
    endtask

    task automatic run_ticks(input int idx, input int n);
        int k;
        begin
            for (k = 0; k < n; k++)
            begin
                tick(idx);
                chk(countdown_flag, (k == n - 1) ? 8'h01 : 8'h00);
            end
        end
    endtask

    // Level interrupt must drop in the very cycle of the clear
    task automatic clear_flag(input logic alarm);
        begin
            @(negedge mclk);
            if (alarm)
                alarm_flag_clr = 1'b1;
            else
                countdown_flag_clr = 1'b1;
            #1;
            chk(int_n, 8'h01);
            @(negedge mclk);
            alarm_flag_clr     = 1'b0;
            countdown_flag_clr = 1'b0;
        end
    endtask

    task automatic wait_alarm;
        int k;
        begin
            for (k = 0; k < 10 && alarm_hit_flag !== 1'b1; k++)
                @(negedge mclk);
            if (k == 10)
            begin
                chk(alarm_hit_flag, 8'h01);
                tally_and_finish;
            end
        end
    endtask

    initial
    begin
        n_errors = 0; cmp_count = 0; rst = 1'b1; ce = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 5'h00; reg_wdata = 8'h00; tk = 5'h00; alarm_irq_en = 1'b0;
        alarm_flag_clr = 1'b0; countdown_flag_clr = 1'b0;
        cur_sec = 7'h04; cur_min = 7'h00; cur_hour = 7'h12; cur_day = 7'h01; cur_wday = 7'h02;
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        chk(int_n, 8'h01);
        for (i = 0; i < 5; i++)
            reg_read(5'h0b + 5'(i), 8'h80);
        reg_read(5'h10, 8'h00);
        reg_read(5'h11, 8'h18);
        reg_write(5'h0f, 8'hff);
        reg_read(5'h0f, 8'h87);
        reg_write(5'h11, 8'hff);
        reg_read(5'h11, 8'h1f);
        reg_write(5'h11, 8'h18);
        reg_write(5'h12, 8'h5a);
        reg_read(5'h12, 8'h00);

        // Alarm on seconds only; disabled hour and weekday fields differ from the time
        reg_write(5'h0b, 8'h05);
        repeat (4) @(negedge mclk);
        chk(alarm_hit_flag, 8'h00);
        cur_sec = 7'h05;
        wait_alarm;
        chk(alarm_hit_flag, 8'h01);
        chk(int_n, 8'h01);
        alarm_irq_en = 1'b1;
        #1;
        chk(int_n, 8'h00);
        clear_flag(1'b1);
        repeat (6) @(negedge mclk);
        chk(alarm_hit_flag, 8'h00);
        cur_sec = 7'h06;
        repeat (4) @(negedge mclk);
        cur_sec = 7'h05;
        wait_alarm;
        clear_flag(1'b1);
        // Weekday enabled too: a seconds match alone must not raise the flag
        reg_write(5'h0f, 8'h03);
        cur_sec = 7'h06;
        repeat (4) @(negedge mclk);
        cur_sec = 7'h05;
        repeat (4) @(negedge mclk);
        chk(alarm_hit_flag, 8'h00);
        cur_wday = 7'h03;
        wait_alarm;
        clear_flag(1'b1);
        alarm_irq_en = 1'b0;

        // Level mode countdown, live read and reload rewritten mid-period
        reg_write(5'h10, 8'h03);
        reg_write(5'h11, 8'h06);
        tick(1);
        reg_read(5'h10, 8'h03);
        tick(1);
        reg_read(5'h10, 8'h02);
        ce = 1'b0;
        tick(1);
        ce = 1'b1;
        reg_read(5'h10, 8'h02);
        run_ticks(1, 2);
        chk(int_n, 8'h00);
        reg_read(5'h10, 8'h03);
        repeat (5) @(negedge mclk);
        chk(countdown_flag, 8'h01);
        reg_write(5'h10, 8'h05);
        reg_read(5'h10, 8'h05);
        clear_flag(1'b0);
        run_ticks(1, 5);
        clear_flag(1'b0);
        run_ticks(1, 5);
        clear_flag(1'b0);

        // Pulse mode: width is one or two 8192 Hz ticks for the fast source
        for (i = 1; i <= 2; i++)
        begin
            reg_write(5'h11, 8'h03);
            reg_write(5'h10, 8'(i));
            reg_write(5'h11, 8'h07);
            tick(1);
            run_ticks(1, i);
            chk(int_n, 8'h00);
            if (i == 2)
            begin
                tick(0);
                chk(int_n, 8'h00);
            end
            tick(0);
            chk(int_n, 8'h01);
            chk(countdown_flag, 8'h01);
            clear_flag(1'b0);
        end
        reg_write(5'h11, 8'h05);
        run_ticks(1, 2);
        chk(int_n, 8'h01);
        clear_flag(1'b0);

        // Loading zero stops the count
        reg_write(5'h11, 8'h06);
        reg_write(5'h10, 8'h00);
        repeat (3) tick(1);
        chk(countdown_flag, 8'h00);
        reg_read(5'h10, 8'h00);

        // Every source; slow ones wait for a 64 Hz tick before counting
        for (i = 0; i < 4; i++)
        begin
            reg_write(5'h11, 8'h00);
            reg_write(5'h10, 8'h01);
            reg_write(5'h11, 8'((i << 3) | 4));
            tick(i + 1);
            chk(countdown_flag, 8'h00);
            if (i >= 2)
                tick(2);
            run_ticks(i + 1, 1);
            chk(int_n, 8'h01);
            clear_flag(1'b0);
        end
        reg_write(5'h11, 8'h18);
        tally_and_finish;
    end

endmodule // rtc_alarm_and_countdown_timer_bench
